// ===== include/butterfly_pkg.sv
/*
  constants, carrier types and behaviour notes for the complex butterfly datapath.
  assumes a single synchronous clock and neighbours that keep to the same signed format.
*/
// Notes on behaviour
// - the block forms a plus b times w and a minus b times w from complex operands.
// - the full-precision result of each component is two times the input width plus two bits.
// - without full resolution each output is the slice starting at the truncation bit.
// - with full resolution both outputs carry the whole full-precision width.
// - all real and imaginary operand parts share one signed width of at least one bit.
// - the datapath has a configurable number of register stages, at least three.
// - output width is at least one and truncation at least zero, used only when not full.
// - with a constant twiddle the w port is unused and fixed real and imaginary values apply.
// - an optional clock enable holds the pipeline while it is low.
// - an optional asynchronous clear empties the pipeline regardless of the clock.
// - all operands and results are two's complement with the top bit as sign.
// - each complex port is split into real and imaginary vectors of fixed widths.
package butterfly_pkg;
  localparam int IN_W        = 16;
  localparam int FULL_W      = 2 * IN_W + 2;
  localparam int OUT_W       = 16;
  localparam int TRUNC_LSB   = 4;
  localparam bit FULL_RES    = 1'b0;
  localparam int RES_W       = FULL_RES ? FULL_W : OUT_W;
  localparam int PIPE_STAGES = 3;
  localparam bit W_CONST     = 1'b0;
  localparam logic signed [IN_W-1:0] W_RE_CONST = 16'h4000;
  localparam logic signed [IN_W-1:0] W_IM_CONST = 16'h0000;
  localparam int FIFO_DEPTH  = 32;

  typedef struct packed {
    logic signed [IN_W-1:0] re;
    logic signed [IN_W-1:0] im;
  } cplx_in_type;

  typedef struct packed {
    logic signed [FULL_W-1:0] re;
    logic signed [FULL_W-1:0] im;
  } cplx_full_type;

  typedef struct packed {
    logic signed [RES_W-1:0] re;
    logic signed [RES_W-1:0] im;
  } cplx_out_type;

  typedef struct packed {
    cplx_in_type a;
    cplx_in_type b;
    cplx_in_type w;
  } operands_type;

  typedef struct packed {
    cplx_out_type res_a;
    cplx_out_type res_b;
  } results_type;
endpackage

// ===== hw/complex_butterfly.sv
/*
  pipelined radix-2 complex butterfly with a result fifo on the output side.
  assumes upstream and downstream synchronous datapath neighbours on sys_clk_i.
*/
`timescale 1ns/1ns

module result_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             clr_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_type;

  fifo_state_type st_r;
  fifo_state_type st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;
  logic load;

  // one-deep output register in front of the array
  always_comb begin
    st_nxt = st_r;
    load   = st_r.count != '0 && (!st_r.out_valid || out_ready_i);
    push   = in_valid_i && (st_r.count != (AW+1)'(DEPTH));
    pop    = load;
    if (out_ready_i && st_r.out_valid) begin
      st_nxt.out_valid = 1'b0;
    end
    if (load) begin
      st_nxt.out_valid = 1'b1;
      st_nxt.out_data  = mem[st_r.rd_ptr];
      st_nxt.rd_ptr    = st_r.rd_ptr + 1'b1;
    end
    if (push) begin
      st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
    end
    st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
    if (clr_i) begin
      st_nxt = '0;
    end
  end

  // clear acts at once, without an edge
  always_ff @(posedge sys_clk_i or posedge rst_i or posedge clr_i) begin
    if (rst_i || clr_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[st_r.wr_ptr] <= in_data_i;
    end
  end

  assign in_ready_o  = st_r.count != (AW+1)'(DEPTH);
  assign out_valid_o = st_r.out_valid;
  assign out_data_o  = st_r.out_data;
endmodule

module cplx_mult (
  input  wire butterfly_pkg::cplx_in_type         b_i,
  input  wire butterfly_pkg::cplx_in_type         w_i,
  output logic signed [2*butterfly_pkg::IN_W-1:0] p_rr_o,
  output logic signed [2*butterfly_pkg::IN_W-1:0] p_ii_o,
  output logic signed [2*butterfly_pkg::IN_W-1:0] p_ri_o,
  output logic signed [2*butterfly_pkg::IN_W-1:0] p_ir_o
);
  localparam int PW = 2 * butterfly_pkg::IN_W;

  // four signed partial products of b times w
  always_comb begin
    p_rr_o = PW'(b_i.re) * PW'(w_i.re);
    p_ii_o = PW'(b_i.im) * PW'(w_i.im);
    p_ri_o = PW'(b_i.re) * PW'(w_i.im);
    p_ir_o = PW'(b_i.im) * PW'(w_i.re);
  end
endmodule

module cplx_addsub (
  input  wire butterfly_pkg::cplx_in_type   a_i,
  input  wire butterfly_pkg::cplx_full_type prod_i,
  output butterfly_pkg::cplx_full_type      sum_o,
  output butterfly_pkg::cplx_full_type      diff_o
);
  localparam int FW = butterfly_pkg::FULL_W;

  // a plus and minus the product, no precision lost
  always_comb begin
    sum_o.re  = FW'(a_i.re) + prod_i.re;
    sum_o.im  = FW'(a_i.im) + prod_i.im;
    diff_o.re = FW'(a_i.re) - prod_i.re;
    diff_o.im = FW'(a_i.im) - prod_i.im;
  end
endmodule

module cplx_slice (
  input  wire butterfly_pkg::cplx_full_type full_i,
  output butterfly_pkg::cplx_out_type       part_o
);
  // full resolution keeps every bit from bit zero
  localparam int LSB = butterfly_pkg::FULL_RES ? 0 : butterfly_pkg::TRUNC_LSB;

  assign part_o.re = full_i.re[LSB +: butterfly_pkg::RES_W];
  assign part_o.im = full_i.im[LSB +: butterfly_pkg::RES_W];
endmodule

module result_delay #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             clr_i,
  input  wire logic             adv_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0]      data_o
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] tap;
  } dly_state_type;

  dly_state_type st_r;
  dly_state_type st_nxt;

  // shift one place on every advance
  always_comb begin
    st_nxt = st_r;
    if (adv_i) begin
      st_nxt.tap[0] = data_i;
      for (int i = 1; i < DEPTH; i++) begin
        st_nxt.tap[i] = st_r.tap[i-1];
      end
    end
  end

  // clear acts at once, without an edge
  always_ff @(posedge sys_clk_i or posedge rst_i or posedge clr_i) begin
    if (rst_i || clr_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign data_o = st_r.tap[DEPTH-1];
endmodule

module complex_butterfly (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ena_i,
  input  wire logic                       aclr_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire butterfly_pkg::cplx_in_type a_i,
  input  wire butterfly_pkg::cplx_in_type b_i,
  input  wire butterfly_pkg::cplx_in_type w_i,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output butterfly_pkg::cplx_out_type     res_a_o,
  output butterfly_pkg::cplx_out_type     res_b_o
);
  localparam int N  = butterfly_pkg::PIPE_STAGES;
  localparam int FW = butterfly_pkg::FULL_W;
  localparam int PW = 2 * butterfly_pkg::IN_W;
  localparam int XS = N - 2;

  // stages 1 and 2; stage 3 onwards lives in the delay line
  typedef struct packed {
    logic [N-1:0]                vld;
    butterfly_pkg::operands_type ops;
    logic signed [PW-1:0]        p_rr;
    logic signed [PW-1:0]        p_ii;
    logic signed [PW-1:0]        p_ri;
    logic signed [PW-1:0]        p_ir;
    butterfly_pkg::cplx_in_type  a_d;
  } bfly_state_type;

  bfly_state_type               st_r;
  bfly_state_type               st_nxt;
  butterfly_pkg::cplx_in_type   twiddle;
  logic signed [PW-1:0]         p_rr;
  logic signed [PW-1:0]         p_ii;
  logic signed [PW-1:0]         p_ri;
  logic signed [PW-1:0]         p_ir;
  butterfly_pkg::cplx_full_type prod;
  butterfly_pkg::cplx_full_type sum_a;
  butterfly_pkg::cplx_full_type sum_b;
  butterfly_pkg::cplx_out_type  part_a;
  butterfly_pkg::cplx_out_type  part_b;
  butterfly_pkg::results_type   sliced;
  butterfly_pkg::results_type   staged;
  butterfly_pkg::results_type   fifo_data;
  logic                         fifo_ready;
  logic                         fifo_valid;
  logic                         advance;

  // fixed twiddle replaces the port when selected
  always_comb begin
    if (butterfly_pkg::W_CONST) begin
      twiddle.re = butterfly_pkg::W_RE_CONST;
      twiddle.im = butterfly_pkg::W_IM_CONST;
    end else begin
      twiddle = w_i;
    end
  end

  // the pipe moves only with enable and room downstream
  assign advance = ena_i && fifo_ready;

  // partial products from the stage 1 operands
  cplx_mult u_cplx_mult (
    .b_i    (st_r.ops.b),
    .w_i    (st_r.ops.w),
    .p_rr_o (p_rr),
    .p_ii_o (p_ii),
    .p_ri_o (p_ri),
    .p_ir_o (p_ir)
  );

  // b times w at full width from the stage 2 products
  always_comb begin
    prod.re = FW'(st_r.p_rr) - FW'(st_r.p_ii);
    prod.im = FW'(st_r.p_ri) + FW'(st_r.p_ir);
  end

  cplx_addsub u_cplx_addsub (
    .a_i    (st_r.a_d),
    .prod_i (prod),
    .sum_o  (sum_a),
    .diff_o (sum_b)
  );

  cplx_slice u_slice_a (
    .full_i (sum_a),
    .part_o (part_a)
  );

  cplx_slice u_slice_b (
    .full_i (sum_b),
    .part_o (part_b)
  );

  assign sliced = {part_a, part_b};

  always_comb begin
    st_nxt = st_r;
    if (advance) begin
      st_nxt.vld   = {st_r.vld[N-2:0], in_valid_i};
      // stage 1: capture operands
      st_nxt.ops.a = a_i;
      st_nxt.ops.b = b_i;
      st_nxt.ops.w = twiddle;
      // stage 2: partial products, a carried alongside
      st_nxt.p_rr  = p_rr;
      st_nxt.p_ii  = p_ii;
      st_nxt.p_ri  = p_ri;
      st_nxt.p_ir  = p_ir;
      st_nxt.a_d   = st_r.ops.a;
    end
  end

  // clear acts at once, without an edge
  always_ff @(posedge sys_clk_i or posedge rst_i or posedge aclr_i) begin
    if (rst_i || aclr_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // stage 3 and any extra stages, in step with vld
  result_delay #(
    .WIDTH ($bits(butterfly_pkg::results_type)),
    .DEPTH (XS)
  ) u_result_delay (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clr_i     (aclr_i),
    .adv_i     (advance),
    .data_i    (sliced),
    .data_o    (staged)
  );

  // fifo holds results; its ready stalls the pipe
  result_fifo #(
    .WIDTH ($bits(butterfly_pkg::results_type)),
    .DEPTH (butterfly_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .clr_i       (aclr_i),
    .in_valid_i  (advance && st_r.vld[N-1]),
    .in_ready_o  (fifo_ready),
    .in_data_i   (staged),
    .out_valid_o (fifo_valid),
    .out_ready_i (out_ready_i),
    .out_data_o  (fifo_data)
  );

  assign in_ready_o  = advance;
  assign out_valid_o = fifo_valid;
  assign res_a_o     = fifo_data.res_a;
  assign res_b_o     = fifo_data.res_b;
endmodule

// ===== testbench/complex_butterfly_props.sv
/* port checker for the butterfly.
   bound onto complex_butterfly below. */
`timescale 1ns/1ns
module butterfly_props (
  input wire logic                        sys_clk_i,
  input wire logic                        rst_i,
  input wire logic                        ena_i,
  input wire logic                        aclr_i,
  input wire logic                        in_valid_i,
  input wire logic                        in_ready_o,
  input wire logic                        out_valid_o,
  input wire logic                        out_ready_i,
  input wire butterfly_pkg::cplx_out_type res_a_o,
  input wire butterfly_pkg::cplx_out_type res_b_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence take_s; in_valid_i && in_ready_o && !aclr_i; endsequence
  sequence run_s; (ena_i && !aclr_i) [*5]; endsequence
  sequence clr_s; aclr_i ##1 !aclr_i; endsequence
  AST_READY_ENA: assert property (!ena_i |-> !in_ready_o)
    else $error("ready while disabled");
  AST_EMPTY_READY: assert property (ena_i && !out_valid_o |-> in_ready_o)
    else $error("not ready while empty");
  AST_HOLD: assert property (out_valid_o && !out_ready_i && !aclr_i |=>
    aclr_i || (out_valid_o && $stable({res_a_o, res_b_o}))) else $error("result dropped");
  AST_CLEAR: assert property (aclr_i |=> !out_valid_o)
    else $error("valid after clear");
  AST_CLR_READY: assert property (aclr_i ##1 ena_i |-> in_ready_o)
    else $error("not ready after clear");
  AST_QUIET: assert property (clr_s |-> !out_valid_o [*3])
    else $error("result too early");
  AST_RST_ZERO: assert property ($fell(rst_i) |-> !out_valid_o && {res_a_o, res_b_o} == '0)
    else $error("outputs not zero");
  AST_LATENCY: assert property (take_s ##1 run_s |-> ##[0:1] out_valid_o)
    else $error("result late");
endmodule
bind complex_butterfly butterfly_props u_butterfly_props (.sys_clk_i, .rst_i, .ena_i, .aclr_i,
  .in_valid_i, .in_ready_o, .out_valid_o, .out_ready_i, .res_a_o, .res_b_o);

// ===== testbench/result_sink.sv
/* downstream sink for butterfly results.
   assumes the bench picks stall and slow modes. */
`timescale 1ns/1ns
module result_sink (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic stall_i,
  input  wire logic slow_i,
  output logic      ready_o
);
  logic tick_r;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) tick_r <= 1'b0;
    else tick_r <= ~tick_r;
  end
  // signed pairs taken every cycle or every other, none while stalled
  assign ready_o = !stall_i && (!slow_i || tick_r);
endmodule

// ===== testbench/test_complex_butterfly.sv
/* self-checking bench for the butterfly.
   assumes the package settings and result_sink. */
`timescale 1ns/1ns
module test_complex_butterfly;
  typedef butterfly_pkg::operands_type ops_type;
  typedef butterfly_pkg::results_type  res_type;
  logic sys_clk_i = 0, rst_i = 1, ena_i = 0, aclr_i = 0, in_valid_i = 0, stall = 0, slow = 0;
  logic in_ready_o, out_valid_o, out_ready_i;
  butterfly_pkg::cplx_in_type  a_i = '0, b_i = '0, w_i = '0;
  butterfly_pkg::cplx_out_type res_a_o, res_b_o;
  res_type expq[$];
  ops_type rows[4];
  int      fail_count = 0, n_checks = 0, k;
  always #20 sys_clk_i = ~sys_clk_i;
  complex_butterfly u_complex_butterfly (.sys_clk_i, .rst_i, .ena_i, .aclr_i, .in_valid_i,
    .in_ready_o, .a_i, .b_i, .w_i, .out_valid_o, .out_ready_i, .res_a_o, .res_b_o);
  result_sink u_result_sink (.sys_clk_i, .rst_i, .stall_i(stall), .slow_i(slow),
    .ready_o(out_ready_i));
  function automatic res_type expect_of(ops_type o);
    longint  pr, pi;
    res_type r;
    pr = longint'(o.b.re) * o.w.re - longint'(o.b.im) * o.w.im;
    pi = longint'(o.b.re) * o.w.im + longint'(o.b.im) * o.w.re;
    r.res_a.re = (o.a.re + pr) >>> butterfly_pkg::TRUNC_LSB;
    r.res_a.im = (o.a.im + pi) >>> butterfly_pkg::TRUNC_LSB;
    r.res_b.re = (o.a.re - pr) >>> butterfly_pkg::TRUNC_LSB;
    r.res_b.im = (o.a.im - pi) >>> butterfly_pkg::TRUNC_LSB;
    return r;
  endfunction
  task automatic chk_res(res_type got, res_type exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t result %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(logic got, logic exp, string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic put(ops_type o);
    int t;
    in_valid_i <= 1;
    {a_i, b_i, w_i} <= o;
    @(negedge sys_clk_i);
    for (t = 0; t < 100 && in_ready_o !== 1'b1; t++) @(negedge sys_clk_i);
    if (t == 100) begin
      chk_bit(0, 1, "ready timeout");
      test_done;
    end
    @(posedge sys_clk_i);
    expq.push_back(expect_of(o));
  endtask
  task automatic drain;
    for (k = 0; k < 400 && expq.size() > 0; k++) @(posedge sys_clk_i);
    chk_bit(expq.size() == 0, 1, "drain timeout");
  endtask
  always @(negedge sys_clk_i) begin
    if (!rst_i && out_valid_o === 1'b1 && out_ready_i) begin
      if (expq.size() == 0) chk_bit(1, 0, "extra result");
      else chk_res({res_a_o, res_b_o}, expq.pop_front());
    end
  end
  initial begin
    rows[0] = {16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h4000, 16'h0000};
    rows[1] = {16'h7fff, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000};
    rows[2] = {16'h0000, 16'h0000, 16'h1234, 16'hfedc, 16'h5a82, 16'ha57e};
    rows[3] = {16'hfff0, 16'h0010, 16'hffff, 16'h0001, 16'h7fff, 16'hffff};
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 0;
    ena_i <= 1;
    @(posedge sys_clk_i);
    chk_bit(out_valid_o, 0, "valid after reset");
    foreach (rows[i]) put(rows[i]);
    in_valid_i <= 0;
    drain;
    $display("rows done");
    put(rows[3]);
    ena_i <= 0;
    {a_i, b_i, w_i} <= rows[1];
    repeat (5) @(posedge sys_clk_i);
    ena_i <= 1;
    put(rows[1]);
    in_valid_i <= 0;
    drain;
    $display("enable done");
    stall <= 1;
    in_valid_i <= 1;
    {a_i, b_i, w_i} <= rows[2];
    repeat (45) begin
      @(negedge sys_clk_i);
      if (in_ready_o === 1'b1) expq.push_back(expect_of(rows[2]));
      @(posedge sys_clk_i);
    end
    @(negedge sys_clk_i);
    chk_bit(in_ready_o, 0, "not full");
    chk_bit(expq.size() >= butterfly_pkg::FIFO_DEPTH, 1, "short fill");
    @(posedge sys_clk_i);
    in_valid_i <= 0;
    stall <= 0;
    slow <= 1;
    drain;
    $display("fill done");
    put(rows[0]);
    put(rows[1]);
    in_valid_i <= 0;
    aclr_i <= 1;
    expq.delete();
    @(posedge sys_clk_i);
    aclr_i <= 0;
    repeat (8) @(posedge sys_clk_i);
    chk_bit(out_valid_o, 0, "valid after clear");
    put(rows[3]);
    in_valid_i <= 0;
    rst_i <= 1;
    expq.delete();
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 0;
    repeat (8) @(posedge sys_clk_i);
    chk_bit(out_valid_o, 0, "valid after reset");
    $display("clear done");
    test_done;
  end
endmodule
